// ===== rtl/e1fc_ctrl.sv
`timescale 1ns/1ns
module e1fc_ctrl import e1fc_pkg::*; #(
  parameter int LINE_KBPS = E1FC_E1_KBPS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic copper_rx_clk,
  input wire logic copper_rx_pos,
  input wire logic copper_rx_neg,
  output logic copper_tx_clk,
  output logic copper_tx_pos,
  output logic copper_tx_neg,
  input wire logic fiber_rx_clk,
  input wire logic fiber_rx_data,
  input wire logic fiber_sd,
  output logic fiber_tx_clk,
  output logic fiber_tx_data,
  input wire logic managed,
  input wire logic [3:0] dip_sw,
  output logic [3:0] peer_cfg,
  output logic peer_cfg_valid
);
  // T1 substitutes eight zeros, E1 four.
  localparam bit IS_T1 = (LINE_KBPS == E1FC_T1_KBPS);
  localparam logic [15:0] ACC_STEP = 16'(LINE_KBPS);
  localparam logic [15:0] ACC_WRAP = 16'(E1FC_CLK_KHZ);

  e1fc_pins_type pins, s1_q, s2_q, s3_q, filt_q, filt_d;
  logic cuclk_prev_q, fclk_prev_q, tick_c, tick_f, tick_ref;
  logic [15:0] acc_q, acc_d;
  e1fc_cfg_type cfg_mgmt_q, cfg_mgmt_d, cfg;
  logic [2:0] status_q, status_d, mask_q, mask_d, ev;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic fiber_ok_q, fef_rx_q, fef_rx_d;
  logic [E1FC_FEF_DET_BITS-1:0] fsh_q, fsh_d;
  logic local_lb, remote_lb, fef_tx, ais;
  logic [3:0] peer_q, peer_d;
  logic peer_v_q, peer_v_d;

  assign pins = {dip_sw, managed, fiber_sd, fiber_rx_data, fiber_rx_clk,
                 copper_rx_neg, copper_rx_pos, copper_rx_clk};

  // A pin change is taken once stages two and three agree.
  always_comb begin
    filt_d = (s3_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
      cuclk_prev_q <= 1'b0;
      fclk_prev_q <= 1'b0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      cuclk_prev_q <= filt_q.cu_clk;
      fclk_prev_q <= filt_q.fiber_clk;
    end
  end

  // Symbol ticks: rising edges of the copper and fiber receive clocks.
  assign tick_c = filt_q.cu_clk & ~cuclk_prev_q;
  assign tick_f = filt_q.fiber_clk & ~fclk_prev_q;

  // Fractional divider gives a local reference at the line rate, used
  // only while no fiber clock can be recovered.
  always_comb begin
    acc_d = acc_q + ACC_STEP;
    tick_ref = 1'b0;
    if (acc_d >= ACC_WRAP) begin
      acc_d = acc_d - ACC_WRAP;
      tick_ref = 1'b1;
    end
  end

  // Managed chassis overrides the switches entirely.
  assign cfg = filt_q.managed ? cfg_mgmt_q : e1fc_cfg_type'(filt_q.dip);
  assign local_lb = (cfg.loop == E1FC_LOOP_LOCAL);
  assign remote_lb = (cfg.loop == E1FC_LOOP_REMOTE);
  assign fef_tx = cfg.fef_en & ~fiber_ok_q;
  assign ais = ~fiber_ok_q | fef_rx_q;

  // Receive fault watch: loss of light and alternating fault pattern.
  always_comb begin
    fsh_d = fsh_q;
    fef_rx_d = fef_rx_q;
    if (tick_f) begin
      fsh_d = {fsh_q[E1FC_FEF_DET_BITS-2:0], filt_q.fiber_data};
      fef_rx_d = &(fsh_d[E1FC_FEF_DET_BITS-2:0] ^
                   fsh_d[E1FC_FEF_DET_BITS-1:1]);
    end
    if (!filt_q.fiber_sd) begin
      fef_rx_d = 1'b0;
    end
    ev = '0;
    ev[E1FC_EV_LOSS] = fiber_ok_q & ~filt_q.fiber_sd;
    ev[E1FC_EV_RESTORE] = ~fiber_ok_q & filt_q.fiber_sd;
    ev[E1FC_EV_FEF_RX] = fef_rx_d & ~fef_rx_q;
  end

  // Register port; a status read clears, but a new event still sets.
  always_comb begin
    cfg_mgmt_d = cfg_mgmt_q;
    mask_d = mask_q;
    rdata_d = '0;
    status_d = status_q;
    if (reg_wr && reg_addr == E1FC_REG_CFG) begin
      cfg_mgmt_d = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == E1FC_REG_MASK) begin
      mask_d = reg_wdata[E1FC_NUM_EV-1:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        E1FC_REG_CFG: rdata_d = {28'h0, cfg_mgmt_q};
        E1FC_REG_STATUS: begin
          rdata_d = {29'h0, status_q};
          status_d = '0;
        end
        E1FC_REG_MASK: rdata_d = {29'h0, mask_q};
        E1FC_REG_STATE: rdata_d = {22'h0, fef_rx_q, ais, fef_tx,
                                   filt_q.managed, fiber_ok_q, 1'b0,
                                   cfg};
        default: rdata_d = '0;
      endcase
    end
    status_d = status_d | ev;
    irq_d = |(status_d & mask_d);
  end

  // Peer relay: managed settings go out whole; a requested remote
  // loopback asks the peer to loop its fiber side.
  always_comb begin
    peer_d = cfg;
    peer_v_d = filt_q.managed;
    if (cfg.loop == E1FC_LOOP_REQUEST) begin
      peer_d[3:2] = E1FC_LOOP_REMOTE;
      peer_v_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= '0;
      cfg_mgmt_q <= E1FC_CFG_RESET;
      mask_q <= E1FC_MASK_RESET;
      status_q <= '0;
      rdata_q <= '0;
      irq_q <= 1'b0;
      fiber_ok_q <= 1'b0;
      fsh_q <= '0;
      fef_rx_q <= 1'b0;
      peer_q <= E1FC_CFG_RESET;
      peer_v_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      cfg_mgmt_q <= cfg_mgmt_d;
      mask_q <= mask_d;
      status_q <= status_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      fiber_ok_q <= filt_q.fiber_sd;
      fsh_q <= fsh_d;
      fef_rx_q <= fef_rx_d;
      peer_q <= peer_d;
      peer_v_q <= peer_v_d;
    end
  end

  // Copper receive decoder. Eight symbols of delay cover the longest
  // substitution, so zeros are restored before a bit leaves.
  logic [E1FC_DEPTH-1:0][1:0] hist_q, hist_d;
  logic [E1FC_DEPTH-1:0] dat_q, dat_d;
  logic dpol_q, dpol_d, dami_q, dami_d, rx_mark, rx_viol;

  always_comb begin
    hist_d = hist_q;
    dat_d = dat_q;
    dpol_d = dpol_q;
    dami_d = dami_q;
    rx_mark = filt_q.cu_pos ^ filt_q.cu_neg;
    rx_viol = rx_mark & (filt_q.cu_pos == dpol_q);
    if (tick_c) begin
      hist_d = {hist_q[E1FC_DEPTH-2:0], filt_q.cu_pos, filt_q.cu_neg};
      dat_d = {dat_q[E1FC_DEPTH-2:0], rx_mark};
      if (rx_mark) begin
        dpol_d = filt_q.cu_pos;
      end
      if (rx_mark && !rx_viol) begin
        dami_d = cfg.line_ami;
      end
      if (!dami_q && !IS_T1 && rx_viol) begin
        dat_d[3:0] = '0;
      end
      if (!dami_q && IS_T1 && hist_d[7:5] == '0 && hist_d[2] == 2'b00 &&
          hist_d[4] != 2'b00 && hist_d[3] != 2'b00 &&
          hist_d[4] == hist_d[0] && hist_d[3] == hist_d[1] &&
          hist_d[4] != hist_d[3]) begin
        dat_d = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hist_q <= '0;
      dat_q <= '0;
      dpol_q <= 1'b0;
      dami_q <= 1'b0;
    end else begin
      hist_q <= hist_d;
      dat_q <= dat_d;
      dpol_q <= dpol_d;
      dami_q <= dami_d;
    end
  end

  // Copper transmit encoder and its timing source.
  e1fc_sym_type [E1FC_DEPTH-1:0] sym_q, sym_d;
  logic tick_tx, tx_bit, tpol_q, tpol_d, par_q, par_d, eami_q, eami_d;
  logic [3:0] run_q, run_d;
  logic cpos_q, cpos_d, cneg_q, cneg_d, cclk_q, cclk_d;

  always_comb begin
    // Local loop follows copper timing; otherwise the recovered fiber
    // clock times the line, falling back to the reference on loss.
    if (local_lb) begin
      tick_tx = tick_c;
      cclk_d = filt_q.cu_clk;
      tx_bit = dat_q[E1FC_DEPTH-1];
    end else if (fiber_ok_q) begin
      tick_tx = tick_f;
      cclk_d = filt_q.fiber_clk;
      tx_bit = ais | filt_q.fiber_data;
    end else begin
      tick_tx = tick_ref;
      cclk_d = tick_ref;
      tx_bit = 1'b1;
    end
    sym_d = sym_q;
    tpol_d = tpol_q;
    par_d = par_q;
    eami_d = eami_q;
    run_d = run_q;
    cpos_d = cpos_q;
    cneg_d = cneg_q;
    if (tick_tx) begin
      unique case (sym_q[E1FC_DEPTH-1])
        E1FC_SYM_ZERO: begin
          cpos_d = 1'b0;
          cneg_d = 1'b0;
        end
        E1FC_SYM_VIOL: begin
          cpos_d = tpol_q;
          cneg_d = ~tpol_q;
        end
        E1FC_SYM_MARK, E1FC_SYM_BIP: begin
          tpol_d = ~tpol_q;
          cpos_d = ~tpol_q;
          cneg_d = tpol_q;
        end
      endcase
      sym_d = {sym_q[E1FC_DEPTH-2:0],
               tx_bit ? E1FC_SYM_MARK : E1FC_SYM_ZERO};
      if (tx_bit) begin
        run_d = '0;
        par_d = ~par_q;
        eami_d = cfg.line_ami;
      end else if (run_q != E1FC_RUN_MAX) begin
        run_d = run_q + 4'h1;
      end
      if (!eami_q && !IS_T1 && run_d == E1FC_HDB3_RUN) begin
        sym_d[0] = E1FC_SYM_VIOL;
        if (!par_q) begin
          sym_d[3] = E1FC_SYM_BIP;
        end
        par_d = 1'b0;
        run_d = '0;
      end
      if (!eami_q && IS_T1 && run_d == E1FC_B8ZS_RUN) begin
        sym_d[4] = E1FC_SYM_VIOL;
        sym_d[3] = E1FC_SYM_BIP;
        sym_d[1] = E1FC_SYM_VIOL;
        sym_d[0] = E1FC_SYM_BIP;
        run_d = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sym_q <= {E1FC_DEPTH{E1FC_SYM_ZERO}};
      tpol_q <= 1'b0;
      par_q <= 1'b0;
      eami_q <= 1'b0;
      run_q <= '0;
      cpos_q <= 1'b0;
      cneg_q <= 1'b0;
      cclk_q <= 1'b0;
    end else begin
      sym_q <= sym_d;
      tpol_q <= tpol_d;
      par_q <= par_d;
      eami_q <= eami_d;
      run_q <= run_d;
      cpos_q <= cpos_d;
      cneg_q <= cneg_d;
      cclk_q <= cclk_d;
    end
  end

  // Fiber transmit: copper data at copper timing, or the fiber input
  // looped back; the fault pattern replaces both on loss of light.
  logic fph_q, fph_d, fdat_q, fdat_d, fclk_q, fclk_d;

  always_comb begin
    fph_d = fph_q;
    fdat_d = fdat_q;
    fclk_d = remote_lb ? filt_q.fiber_clk : filt_q.cu_clk;
    if (remote_lb ? tick_f : tick_c) begin
      fph_d = ~fph_q;
      if (fef_tx) begin
        fdat_d = fph_q;
      end else if (remote_lb) begin
        fdat_d = filt_q.fiber_data;
      end else begin
        fdat_d = dat_q[E1FC_DEPTH-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fph_q <= 1'b0;
      fdat_q <= 1'b0;
      fclk_q <= 1'b0;
    end else begin
      fph_q <= fph_d;
      fdat_q <= fdat_d;
      fclk_q <= fclk_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign copper_tx_clk = cclk_q;
  assign copper_tx_pos = cpos_q;
  assign copper_tx_neg = cneg_q;
  assign fiber_tx_clk = fclk_q;
  assign fiber_tx_data = fdat_q;
  assign peer_cfg = peer_q;
  assign peer_cfg_valid = peer_v_q;
endmodule : e1fc_ctrl

// ===== rtl/e1fc_pkg.sv
package e1fc_pkg;
  // Core clock and the two line rates, all in kHz or kbit/s.
  localparam int E1FC_CLK_KHZ = 25000;
  localparam int E1FC_E1_KBPS = 2048;
  localparam int E1FC_T1_KBPS = 1544;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] E1FC_REG_CFG = 8'h00;
  localparam logic [7:0] E1FC_REG_STATUS = 8'h04;
  localparam logic [7:0] E1FC_REG_MASK = 8'h08;
  localparam logic [7:0] E1FC_REG_STATE = 8'h0c;

  // Event bit positions shared by status and mask.
  localparam int E1FC_EV_LOSS = 0;
  localparam int E1FC_EV_RESTORE = 1;
  localparam int E1FC_EV_FEF_RX = 2;
  localparam int E1FC_NUM_EV = 3;

  // Line code history depths: HDB3 needs four symbols, B8ZS eight.
  localparam int E1FC_DEPTH = 8;
  localparam logic [3:0] E1FC_HDB3_RUN = 4'h4;
  localparam logic [3:0] E1FC_B8ZS_RUN = 4'h8;
  localparam logic [3:0] E1FC_RUN_MAX = 4'hf;
  // Bits of alternating pattern that mark a far-end fault on receive.
  localparam int E1FC_FEF_DET_BITS = 32;

  // Values after reset.
  localparam logic [3:0] E1FC_CFG_RESET = 4'h0;
  localparam logic [2:0] E1FC_MASK_RESET = 3'h0;

  typedef enum logic [1:0] {
    E1FC_LOOP_NORMAL,
    E1FC_LOOP_LOCAL,
    E1FC_LOOP_REMOTE,
    E1FC_LOOP_REQUEST
  } e1fc_loop_type;

  typedef enum logic [1:0] {
    E1FC_SYM_ZERO,
    E1FC_SYM_MARK,
    E1FC_SYM_VIOL,
    E1FC_SYM_BIP
  } e1fc_sym_type;

  // Same layout as the four front switches, switch 1 in bit 0.
  typedef struct packed {
    e1fc_loop_type loop;
    logic fef_en;
    logic line_ami;
  } e1fc_cfg_type;

  // All pins that come from outside the clock domain.
  typedef struct packed {
    logic [3:0] dip;
    logic managed;
    logic fiber_sd;
    logic fiber_data;
    logic fiber_clk;
    logic cu_neg;
    logic cu_pos;
    logic cu_clk;
  } e1fc_pins_type;
endpackage : e1fc_pkg

// ===== tb/e1fc_ctrl_assertions.sv
`timescale 1ns/1ns
module e1fc_ctrl_assertions import e1fc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic copper_tx_clk,
  input wire logic copper_tx_pos,
  input wire logic copper_tx_neg,
  input wire logic fiber_sd,
  input wire logic managed,
  input wire logic [3:0] dip_sw,
  input wire logic [3:0] peer_cfg,
  input wire logic peer_cfg_valid
);
  logic [8:0] loss_d;
  logic [8:0] loss_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles without light, held at 300 so that the pipeline has long drained.
  always_comb begin
    loss_d = fiber_sd ? 9'h000 : loss_q + {8'h00, loss_q != 9'h12c};
  end
  always_ff @(posedge clk) begin
    loss_q <= rst_n ? loss_d : 9'h000;
  end
  // A configuration write followed by its read back.
  sequence s_cfg_wr;
    reg_wr && reg_addr == E1FC_REG_CFG;
  endsequence
  sequence s_cfg_rd;
    reg_rd && reg_addr == E1FC_REG_CFG;
  endsequence
  a_cfg_read_back: assert property (s_cfg_wr ##2 s_cfg_rd |=>
    reg_rdata == {28'h0, $past(reg_wdata[3:0], 3)})
    else $error("config read back differs from write");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |->
    reg_rdata == 32'h0) else $error("read data not zero when idle");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h10 |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_mask_width: assert property (reg_rd && reg_addr == E1FC_REG_MASK |=>
    reg_rdata[31:3] == 29'h0) else $error("mask upper bits not zero");
  a_bipolar_legal: assert property (!(copper_tx_pos && copper_tx_neg))
    else $error("both copper polarities driven");
  a_ais_all_ones: assert property (loss_q == 9'h12c && copper_tx_clk |->
    copper_tx_pos ^ copper_tx_neg) else $error("AIS symbol is not a mark");
  a_request_peer: assert property ((!managed && dip_sw == 4'hc)[*8] |->
    peer_cfg_valid && peer_cfg[3:2] == 2'b10)
    else $error("loop request not relayed");
  a_managed_relay: assert property (managed[*8] |-> peer_cfg_valid)
    else $error("managed config not relayed");
endmodule : e1fc_ctrl_assertions

bind e1fc_ctrl e1fc_ctrl_assertions u_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .copper_tx_clk(copper_tx_clk),
  .copper_tx_pos(copper_tx_pos), .copper_tx_neg(copper_tx_neg),
  .fiber_sd(fiber_sd), .managed(managed), .dip_sw(dip_sw),
  .peer_cfg(peer_cfg), .peer_cfg_valid(peer_cfg_valid));

// ===== tb/e1fc_line_model.sv
`timescale 1ns/1ns
module e1fc_line_model #(
  parameter logic [15:0] PAT_CU = 16'h8101,
  parameter logic [15:0] PAT_FB = 16'hc0a0
) (
  input wire logic cu_ami,
  input wire logic fb_alt,
  output logic copper_rx_clk,
  output logic copper_rx_pos,
  output logic copper_rx_neg,
  output logic fiber_rx_clk,
  output logic fiber_rx_data
);
  logic last;
  function automatic logic cu_bit(input int k);
    return PAT_CU[15 - (k % 16)];
  endfunction : cu_bit
  // The copper equipment times the line itself; data changes on the fall.
  task automatic sym(input logic p, input logic n);
    copper_rx_pos = p;
    copper_rx_neg = n;
    #160 copper_rx_clk = 1'b1;
    #160 copper_rx_clk = 1'b0;
  endtask : sym
  // A violation keeps the polarity, a normal mark alternates it.
  task automatic mark(input logic flip);
    if (flip) last = !last;
    sym(last, !last);
  endtask : mark
  // HDB3 or AMI line coding of the repeating copper pattern.
  initial begin
    int i;
    int marks;
    i = 0;
    marks = 0;
    last = 1'b0;
    copper_rx_clk = 1'b0;
    copper_rx_pos = 1'b0;
    copper_rx_neg = 1'b0;
    #7;
    forever begin
      if (!cu_ami && !cu_bit(i) && !cu_bit(i + 1) && !cu_bit(i + 2)
          && !cu_bit(i + 3)) begin
        if (marks % 2 == 1) sym(1'b0, 1'b0);
        else mark(1'b1);
        sym(1'b0, 1'b0);
        sym(1'b0, 1'b0);
        mark(1'b0);
        marks = 0;
        i += 4;
      end else begin
        if (cu_bit(i)) begin
          mark(1'b1);
          marks++;
        end else sym(1'b0, 1'b0);
        i++;
      end
    end
  end
  // Remote converter sends an unframed clear channel stream.
  initial begin
    int k;
    k = 0;
    fiber_rx_clk = 1'b0;
    fiber_rx_data = 1'b0;
    #101;
    forever begin
      // A far converter that lost its light sends the alternating fault.
      fiber_rx_data = fb_alt ? k[0] : PAT_FB[15 - (k % 16)];
      #160 fiber_rx_clk = 1'b1;
      #160 fiber_rx_clk = 1'b0;
      k++;
    end
  end
endmodule : e1fc_line_model

// ===== tb/e1fc_ctrl_tb.sv
`timescale 1ns/1ns
module e1fc_ctrl_tb import e1fc_pkg::*; ;
  logic clk, rst_n, reg_wr, reg_rd, irq, cu_ami, fiber_sd, managed, fb_alt;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic cr_clk, cr_pos, cr_neg, ct_clk, ct_pos, ct_neg;
  logic fr_clk, fr_data, ft_clk, ft_data, peer_cfg_valid;
  logic [3:0] dip_sw, peer_cfg;
  int n_errors, checks, cyc;
  e1fc_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .copper_rx_clk(cr_clk),
    .copper_rx_pos(cr_pos), .copper_rx_neg(cr_neg), .copper_tx_clk(ct_clk),
    .copper_tx_pos(ct_pos), .copper_tx_neg(ct_neg), .fiber_rx_clk(fr_clk),
    .fiber_rx_data(fr_data), .fiber_sd(fiber_sd), .fiber_tx_clk(ft_clk),
    .fiber_tx_data(ft_data), .managed(managed), .dip_sw(dip_sw),
    .peer_cfg(peer_cfg), .peer_cfg_valid(peer_cfg_valid));
  e1fc_line_model far (.cu_ami(cu_ami), .fb_alt(fb_alt), .copper_rx_clk(cr_clk),
    .copper_rx_pos(cr_pos), .copper_rx_neg(cr_neg), .fiber_rx_clk(fr_clk),
    .fiber_rx_data(fr_data));
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) v = reg_rdata;
  endtask : rd
  // Collects 16 symbols at rises of a transmit clock, after the pipe drains.
  task automatic strm(input string what, input logic cu, logic [15:0] p);
    logic [15:0] s;
    logic [31:0] t;
    logic pv, c, hit;
    int n;
    {s, pv, n, hit, t} = {16'h0, 1'b1, 32'h0, 1'b0, p, p};
    repeat (200) @(posedge clk);
    while (n < 16) begin
      @(negedge clk) c = cu ? ct_clk : ft_clk;
      if (c && !pv) s = {s[14:0], cu ? (ct_pos | ct_neg) : ft_data};
      if (c && !pv) n++;
      pv = c;
    end
    for (int k = 0; k < 16; k++) if (t[k +: 16] === s) hit = 1'b1;
    chk(what, 32'h1, {31'h0, hit});
  endtask : strm
  task automatic t_regs;
    rd(E1FC_REG_CFG); chk("cfg reset", 32'h0, v);
    rd(E1FC_REG_MASK); chk("mask reset", 32'h0, v);
    wr(8'h10, 32'hffffffff);
    rd(8'h10); chk("unmapped", 32'h0, v);
    wr(E1FC_REG_MASK, 32'hffffffff);
    rd(E1FC_REG_MASK); chk("mask", 32'h7, v);
    wr(E1FC_REG_CFG, 32'h6);
    rd(E1FC_REG_CFG); chk("cfg", 32'h6, v);
    wr(E1FC_REG_CFG, 32'h0);
  endtask : t_regs
  task automatic t_paths(input logic ami);
    @(posedge clk) {dip_sw, cu_ami} <= {3'h0, ami, ami};
    strm("to fiber", 1'b0, 16'h8101);
    // HDB3 puts B00V marks into both zero runs of the fiber pattern.
    strm("to copper", 1'b1, ami ? 16'hc0a0 : 16'he4b2);
  endtask : t_paths
  task automatic t_loops;
    @(posedge clk) dip_sw <= 4'h4;
    strm("local loop", 1'b1, 16'hc911);
    @(posedge clk) dip_sw <= 4'h8;
    strm("remote loop", 1'b0, 16'hc0a0);
    @(posedge clk) dip_sw <= 4'hc;
    strm("request", 1'b0, 16'h8101);
    chk("peer", 32'h3, {30'h0, peer_cfg_valid, peer_cfg == 4'h8});
  endtask : t_loops
  task automatic t_fault;
    @(posedge clk) dip_sw <= 4'h2;
    wr(E1FC_REG_MASK, 32'h1);
    rd(E1FC_REG_STATUS);
    @(posedge clk) fiber_sd <= 1'b0;
    repeat (400) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    strm("fault pattern", 1'b0, 16'haaaa);
    strm("AIS", 1'b1, 16'hffff);
    rd(E1FC_REG_STATUS); chk("loss event", 32'h1, v);
    @(posedge clk) fiber_sd <= 1'b1;
    strm("resumed", 1'b0, 16'h8101);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(E1FC_REG_STATUS); chk("restore event", 32'h2, v);
  endtask : t_fault
  // The far end reports its own loss; AIS must reach the copper side.
  task automatic t_far_fault;
    @(posedge clk) fb_alt <= 1'b1;
    wr(E1FC_REG_MASK, 32'h4);
    repeat (400) @(posedge clk);
    chk("far irq", 32'h1, {31'h0, irq});
    strm("far AIS", 1'b1, 16'hffff);
    rd(E1FC_REG_STATE); chk("far state", 32'h3, {30'h0, v[9:8]});
    @(posedge clk) fb_alt <= 1'b0;
    repeat (100) @(posedge clk);
    rd(E1FC_REG_STATUS); chk("far event", 32'h4, v);
    strm("far ended", 1'b1, 16'he4b2);
  endtask : t_far_fault
  task automatic t_managed;
    @(posedge clk) {managed, dip_sw, cu_ami} <= {1'b1, 4'hc, 1'b1};
    wr(E1FC_REG_CFG, 32'h1);
    strm("managed code", 1'b0, 16'h8101);
    chk("relay", 32'h11, {27'h0, peer_cfg_valid, peer_cfg});
    rd(E1FC_REG_STATE); chk("state", 32'h11, {27'h0, v[6], v[3:0]});
  endtask : t_managed
  // Free running core clock and a hang guard on it.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) n_errors++;
    if (cyc == 20000) end_of_test();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 43'h0;
    // Light present, standalone, all switches off.
    {fb_alt, cu_ami, fiber_sd, managed, dip_sw} = 8'h20;
    {n_errors, checks, cyc} = 96'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_regs();
    t_paths(1'b0);
    t_paths(1'b1);
    t_loops();
    t_fault();
    t_far_fault();
    t_managed();
    end_of_test();
  end
endmodule : e1fc_ctrl_tb
